// ===== rtl/clock_power_ctrl.sv
// Function
// - prescaler changes divide rate without glitches or short intermediate periods
// - new rate starts after one old plus one new period, two edges between
// - prescaler is a fast counter on the undivided clock, count unreadable
// - code 110 with external crystal enters standby: power-down but oscillator on
// - standby wake-up resumes clocking after six clock cycles
// - power-save stops main oscillator; timer2 synchronous clock stops during sleep
// - clock domains kept per sleep mode; cpu and flash stop always
// - wake sources accepted per sleep mode as listed
// - outside idle external interrupt zero wakes only in level mode
// - idle and adc modes: timer oscillator and timer2 wake only when synchronous
// - power reduction bit stops module clock and blocks its register access
// - clearing the bit restarts the clock, module resumes frozen state
// - per-module shutdown acts in active and idle; sleep gating covers others
// - power reduction bits 7..4 always read zero
// - bit 3 shuts timer1 clock; clearing lets timer1 continue
`timescale 1ns/10ps
`default_nettype none
module clock_power_ctrl
  import clock_power_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic sleep_instr_i,
  input wire logic ext_crystal_sel_i,
  input wire logic timer2_async_i,
  input wire logic external_interrupt_zero_level_mode_i,
  input wire logic external_interrupt_zero_i,
  input wire logic pin_change_i,
  input wire logic universal_serial_unit_start_i,
  input wire logic timer2_wake_i,
  input wire logic self_program_store_ready_i,
  input wire logic adc_done_i,
  input wire logic other_io_wake_i,
  output logic cpu_clk_en_o,
  output logic flash_clk_en_o,
  output logic io_clk_en_o,
  output logic adc_clk_en_o,
  output logic asy_clk_en_o,
  output logic main_osc_en_o,
  output logic timer_osc_en_o,
  output logic timer2_sync_clk_en_o,
  output logic [PRR_W-1:0] periph_clk_en_o,
  output logic [PRR_W-1:0] periph_access_en_o,
  output logic sleeping_o
);

  // ************************************************************
  // wishbone slave and software registers
  // ************************************************************
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic sleep_en_ff;
  logic nxt_sleep_en;
  logic [2:0] sleep_kind_ff;
  logic [2:0] nxt_sleep_kind;
  logic [PRR_W-1:0] prr_ff;
  logic [PRR_W-1:0] nxt_prr;
  logic bus_wr;
  logic prescale_wr;

  power_state_t state_ff;
  power_state_t nxt_state;
  sleep_mode_t mode_ff;
  sleep_mode_t nxt_mode;
  logic [DIV_SEL_W-1:0] div_ff;
  logic [DIV_SEL_W-1:0] nxt_div;
  logic [DIV_SEL_W-1:0] pend_div_ff;
  logic [DIV_SEL_W-1:0] nxt_pend_div;
  logic pend_ff;
  logic nxt_pend;

  // a single-cycle answer: every access is acked the cycle after it is seen
  assign bus_wr = cyc_i & stb_i & ~ack_ff & we_i & sel_i[0];
  assign prescale_wr = bus_wr & (adr_i == ADDR_PRESCALE);

  always_comb begin
    nxt_ack = cyc_i & stb_i & ~ack_ff;
    nxt_sleep_en = sleep_en_ff;
    nxt_sleep_kind = sleep_kind_ff;
    nxt_prr = prr_ff;
    nxt_rdata = 32'h0000_0000;
    if (bus_wr && adr_i == ADDR_SLEEP_CTRL) begin
      nxt_sleep_en = dat_i[SLEEP_EN_BIT];
      nxt_sleep_kind = dat_i[SLEEP_KIND_LSB +: SLEEP_KIND_W];
    end
    if (bus_wr && adr_i == ADDR_POWER_RED) begin
      nxt_prr = dat_i[PRR_W-1:0];
    end
    if (cyc_i && stb_i && !ack_ff && !we_i) begin
      unique case (adr_i)
        ADDR_PRESCALE: begin
          // the running count stays hidden; only the selected rate and a pending flag show
          nxt_rdata[DIV_SEL_W-1:0] = div_ff;
          nxt_rdata[PRESCALE_PEND_BIT] = pend_ff;
        end
        ADDR_SLEEP_CTRL: begin
          nxt_rdata[SLEEP_EN_BIT] = sleep_en_ff;
          nxt_rdata[SLEEP_KIND_LSB +: SLEEP_KIND_W] = sleep_kind_ff;
        end
        ADDR_POWER_RED: begin
          nxt_rdata[PRR_W-1:0] = prr_ff;
        end
        ADDR_STATUS: begin
          nxt_rdata[STAT_STATE_LSB +: 2] = state_ff;
          nxt_rdata[STAT_MODE_LSB +: 3] = mode_ff;
        end
        default: begin
          nxt_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      sleep_en_ff <= 1'b0;
      sleep_kind_ff <= SLEEP_KIND_RESET;
      prr_ff <= PRR_RESET;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      sleep_en_ff <= nxt_sleep_en;
      sleep_kind_ff <= nxt_sleep_kind;
      prr_ff <= nxt_prr;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = rdata_ff;

  // ************************************************************
  // system clock prescaler
  // ************************************************************
  logic [PRESCALE_W-1:0] cnt_ff;
  logic [PRESCALE_W-1:0] nxt_cnt;
  logic [PRESCALE_W-1:0] div_mask;
  logic tick;
  logic osc_run;

  always_comb begin
    div_mask = PRESCALE_W'((9'h001 << div_ff) - 9'h001);
  end

  // a new rate is taken only at the old rate's terminal edge and the count restarts
  // from zero, so the bridging period is one whole old period then one whole new one
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_div = div_ff;
    nxt_pend = pend_ff;
    nxt_pend_div = pend_div_ff;
    tick = 1'b0;
    if (osc_run) begin
      if (cnt_ff == div_mask) begin
        tick = 1'b1;
        nxt_cnt = 8'h00;
        if (pend_ff) begin
          nxt_div = pend_div_ff;
          nxt_pend = 1'b0;
        end
      end else begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end
    // reserved codes are ignored; a write in the applying cycle lets the older rate apply and stays pending itself
    if (prescale_wr && dat_i[DIV_SEL_W-1:0] <= DIV_SEL_MAX) begin
      nxt_pend = 1'b1;
      nxt_pend_div = dat_i[DIV_SEL_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 8'h00;
      div_ff <= DIV_SEL_RESET;
      pend_ff <= 1'b0;
      pend_div_ff <= DIV_SEL_RESET;
    end else begin
      cnt_ff <= nxt_cnt;
      div_ff <= nxt_div;
      pend_ff <= nxt_pend;
      pend_div_ff <= nxt_pend_div;
    end
  end

  // ************************************************************
  // sleep state machine and wake-up
  // ************************************************************
  logic [WAKE_CNT_W-1:0] wake_cnt_ff;
  logic [WAKE_CNT_W-1:0] nxt_wake_cnt;
  logic wake_ok;
  logic external_interrupt_zero_ok;
  sleep_mode_t req_mode;
  logic req_valid;

  always_comb begin
    req_valid = 1'b1;
    req_mode = MODE_IDLE;
    unique case (sleep_kind_ff)
      SLEEP_KIND_IDLE: req_mode = MODE_IDLE;
      SLEEP_KIND_ADC: req_mode = MODE_ADC;
      SLEEP_KIND_PDOWN: req_mode = MODE_PDOWN;
      SLEEP_KIND_PSAVE: req_mode = MODE_PSAVE;
      // without a crystal the oscillator may not be kept; fall back to power-down
      SLEEP_KIND_STANDBY: req_mode = ext_crystal_sel_i ? MODE_STANDBY : MODE_PDOWN;
      default: req_valid = 1'b0;
    endcase
  end

  always_comb begin
    external_interrupt_zero_ok = external_interrupt_zero_i & external_interrupt_zero_level_mode_i;
    wake_ok = 1'b0;
    unique case (mode_ff)
      MODE_IDLE: begin
        wake_ok = external_interrupt_zero_i | pin_change_i | universal_serial_unit_start_i
          | (timer2_wake_i & ~timer2_async_i) | self_program_store_ready_i
          | adc_done_i | other_io_wake_i;
      end
      MODE_ADC: begin
        wake_ok = external_interrupt_zero_ok | pin_change_i | universal_serial_unit_start_i
          | (timer2_wake_i & ~timer2_async_i) | self_program_store_ready_i | adc_done_i;
      end
      MODE_PSAVE: begin
        wake_ok = external_interrupt_zero_ok | pin_change_i | universal_serial_unit_start_i | timer2_wake_i;
      end
      MODE_PDOWN, MODE_STANDBY: begin
        wake_ok = external_interrupt_zero_ok | pin_change_i | universal_serial_unit_start_i;
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_mode = mode_ff;
    nxt_wake_cnt = wake_cnt_ff;
    unique case (state_ff)
      PWR_ACTIVE: begin
        if (sleep_instr_i && sleep_en_ff && req_valid) begin
          nxt_state = PWR_SLEEP;
          nxt_mode = req_mode;
        end
      end
      PWR_SLEEP: begin
        if (wake_ok) begin
          nxt_state = PWR_WAKE;
          unique case (mode_ff)
            MODE_STANDBY: nxt_wake_cnt = STANDBY_WAKE_CYCLES - 8'h01;
            MODE_PDOWN, MODE_PSAVE: nxt_wake_cnt = OSC_START_CYCLES - 8'h01;
            default: nxt_wake_cnt = 8'h00;
          endcase
        end
      end
      PWR_WAKE: begin
        if (wake_cnt_ff == 8'h00) begin
          nxt_state = PWR_ACTIVE;
        end else begin
          nxt_wake_cnt = wake_cnt_ff - 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= PWR_ACTIVE;
      mode_ff <= MODE_IDLE;
      wake_cnt_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      wake_cnt_ff <= nxt_wake_cnt;
    end
  end

  // ************************************************************
  // clock domain gating
  // ************************************************************
  logic dom_cpu;
  logic dom_io;
  logic dom_adc;
  logic dom_asy;
  logic dom_tosc;
  logic dom_t2sync;
  logic cpu_en_ff;
  logic flash_en_ff;
  logic io_en_ff;
  logic adc_en_ff;
  logic asy_en_ff;
  logic osc_en_ff;
  logic tosc_en_ff;
  logic t2sync_en_ff;
  logic [PRR_W-1:0] access_en_ff;
  logic sleep_ff;

  always_comb begin
    dom_cpu = 1'b0;
    dom_io = 1'b0;
    dom_adc = 1'b0;
    dom_asy = 1'b0;
    osc_run = 1'b0;
    dom_tosc = timer2_async_i;
    dom_t2sync = ~timer2_async_i;
    if (state_ff == PWR_ACTIVE) begin
      dom_cpu = 1'b1;
      dom_io = 1'b1;
      dom_adc = 1'b1;
      dom_asy = 1'b1;
      osc_run = 1'b1;
    end else begin
      // the synchronous timer2 clock stops whatever the mode
      dom_t2sync = 1'b0;
      unique case (mode_ff)
        MODE_IDLE: begin
          dom_io = 1'b1;
          dom_adc = 1'b1;
          dom_asy = 1'b1;
          osc_run = 1'b1;
          dom_tosc = ~timer2_async_i;
        end
        MODE_ADC: begin
          dom_adc = 1'b1;
          dom_asy = 1'b1;
          osc_run = 1'b1;
          dom_tosc = ~timer2_async_i;
        end
        MODE_PSAVE: begin
          dom_asy = 1'b1;
          dom_tosc = 1'b1;
        end
        MODE_STANDBY: begin
          osc_run = 1'b1;
          dom_tosc = 1'b0;
        end
        MODE_PDOWN: begin
          dom_tosc = 1'b0;
        end
      endcase
      // waking: the oscillator restarts and the wake count runs down to zero before the cpu runs
      if (state_ff == PWR_WAKE) begin
        osc_run = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_en_ff <= 1'b0;
      flash_en_ff <= 1'b0;
      io_en_ff <= 1'b0;
      adc_en_ff <= 1'b0;
      asy_en_ff <= 1'b0;
      osc_en_ff <= 1'b0;
      tosc_en_ff <= 1'b0;
      t2sync_en_ff <= 1'b0;
      access_en_ff <= '0;
      sleep_ff <= 1'b0;
    end else begin
      cpu_en_ff <= tick & dom_cpu;
      flash_en_ff <= tick & dom_cpu;
      io_en_ff <= tick & dom_io;
      adc_en_ff <= tick & dom_adc;
      asy_en_ff <= dom_asy;
      osc_en_ff <= osc_run;
      tosc_en_ff <= dom_tosc;
      t2sync_en_ff <= tick & dom_t2sync;
      access_en_ff <= ~prr_ff;
      sleep_ff <= state_ff != PWR_ACTIVE;
    end
  end

  assign cpu_clk_en_o = cpu_en_ff;
  assign flash_clk_en_o = flash_en_ff;
  assign io_clk_en_o = io_en_ff;
  assign adc_clk_en_o = adc_en_ff;
  assign asy_clk_en_o = asy_en_ff;
  assign main_osc_en_o = osc_en_ff;
  assign timer_osc_en_o = tosc_en_ff;
  assign timer2_sync_clk_en_o = t2sync_en_ff;
  assign periph_access_en_o = access_en_ff;
  assign sleeping_o = sleep_ff;

  // ************************************************************
  // per-peripheral clock gates
  // ************************************************************
  // a stopped module simply sees no enable pulses, so its flops hold their state;
  // anything it owns stays owned, which software must handle first
  logic io_src;

  assign io_src = tick & dom_io;

  genvar gi;
  generate
    for (gi = 0; gi < PRR_W; gi = gi + 1) begin : g_gate
      periph_clock_gate u_gate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .src_en_i(io_src),
        .off_i(prr_ff[gi]),
        .clk_en_o(periph_clk_en_o[gi])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// ===== pkg/clock_power_pkg.sv
// ************************************************************
// register map, fields and timing of the clock/power block
// ************************************************************
package clock_power_pkg;

  // ************************************************************
  // wishbone register offsets (byte addresses, one word each)
  // ************************************************************
  localparam logic [7:0] ADDR_PRESCALE = 8'h00;
  localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h04;
  localparam logic [7:0] ADDR_POWER_RED = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // ************************************************************
  // prescaler
  // ************************************************************
  localparam int DIV_SEL_W = 4;
  localparam int PRESCALE_W = 8;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_MAX = 4'h8;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_RESET = 4'h0;
  localparam int PRESCALE_PEND_BIT = 4;

  // ************************************************************
  // sleep control fields and mode codes
  // ************************************************************
  localparam int SLEEP_EN_BIT = 0;
  localparam int SLEEP_KIND_LSB = 1;
  localparam int SLEEP_KIND_W = 3;
  localparam logic [2:0] SLEEP_KIND_IDLE = 3'h0;
  localparam logic [2:0] SLEEP_KIND_ADC = 3'h1;
  localparam logic [2:0] SLEEP_KIND_PDOWN = 3'h2;
  localparam logic [2:0] SLEEP_KIND_PSAVE = 3'h3;
  localparam logic [2:0] SLEEP_KIND_STANDBY = 3'h6;
  localparam logic [2:0] SLEEP_KIND_RESET = 3'h0;

  // ************************************************************
  // peripheral power reduction
  // ************************************************************
  localparam int PRR_W = 4;
  localparam int PRR_TIMER1_BIT = 3;
  localparam logic [PRR_W-1:0] PRR_RESET = 4'h0;

  // ************************************************************
  // status register fields
  // ************************************************************
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MODE_LSB = 4;

  // ************************************************************
  // wake-up timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_CNT_W = 8;
  localparam logic [WAKE_CNT_W-1:0] STANDBY_WAKE_CYCLES = 8'h06;
  localparam int OSC_START_NS = 1000;
  localparam logic [WAKE_CNT_W-1:0] OSC_START_CYCLES =
    WAKE_CNT_W'((OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_SLEEP, PWR_WAKE} power_state_t;
  typedef enum logic [2:0] {MODE_IDLE, MODE_ADC, MODE_PDOWN, MODE_PSAVE, MODE_STANDBY} sleep_mode_t;

endpackage

// ===== rtl/periph_clock_gate.sv
`timescale 1ns/10ps
`default_nettype none
module periph_clock_gate
  import clock_power_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic src_en_i,
  input wire logic off_i,
  output logic clk_en_o
);

  logic en_ff;
  logic nxt_en;

  // the enable only changes between source pulses, so a pulse is passed whole or not at all
  always_comb begin
    nxt_en = src_en_i & ~off_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_ff <= 1'b0;
    end else begin
      en_ff <= nxt_en;
    end
  end

  assign clk_en_o = en_ff;

endmodule
`default_nettype wire

// ===== sim/clock_power_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module clock_power_ctrl_monitor
  import clock_power_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire logic cpu_clk_en_o,
  input wire logic flash_clk_en_o,
  input wire logic io_clk_en_o,
  input wire logic adc_clk_en_o,
  input wire logic main_osc_en_o,
  input wire logic timer2_async_i,
  input wire logic timer2_sync_clk_en_o,
  input wire logic [PRR_W-1:0] periph_clk_en_o,
  input wire logic [PRR_W-1:0] periph_access_en_o,
  input wire logic sleeping_o
);
  // ************************************************************
  // port relations
  // ************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence ack_s;
    ack_o ##1 !ack_o;
  endsequence
  bus_answer_a: assert property (req_s |=> ack_s)
    else $error("bus request not acked for exactly one cycle");
  read_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");
  prr_reserved_a: assert property (ack_o && $past(adr_i) == ADDR_POWER_RED |-> dat_o[31:4] == 28'h0)
    else $error("power reduction upper bits not zero");
  cpu_stop_a: assert property (sleeping_o |-> !cpu_clk_en_o && !flash_clk_en_o)
    else $error("cpu or flash clock runs while sleeping");
  periph_gate_a: assert property (!periph_access_en_o[3] |-> !periph_clk_en_o[3])
    else $error("timer1 clock runs while powered off");
  periph_io_a: assert property (periph_clk_en_o != 4'h0 |-> io_clk_en_o)
    else $error("peripheral clock without io clock");
  osc_off_a: assert property (sleeping_o && !main_osc_en_o |-> !io_clk_en_o && !adc_clk_en_o)
    else $error("domain clock runs with oscillator stopped");
  t2_sync_a: assert property (timer2_sync_clk_en_o |-> !sleeping_o && !$past(timer2_async_i))
    else $error("timer2 synchronous clock outside active mode");
endmodule
bind clock_power_ctrl clock_power_ctrl_monitor i_mon (.clk_i, .rst_i, .adr_i, .cyc_i, .stb_i, .ack_o, .dat_o,
  .cpu_clk_en_o, .flash_clk_en_o, .io_clk_en_o, .adc_clk_en_o, .main_osc_en_o, .timer2_async_i,
  .timer2_sync_clk_en_o, .periph_clk_en_o, .periph_access_en_o, .sleeping_o);
`default_nettype wire

// ===== sim/gated_periph_model.sv
`timescale 1ns/10ps
`default_nettype none
module gated_periph_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  output logic [15:0] count_o
);
  // ************************************************************
  // counter that only moves on its gated clock
  // ************************************************************
  logic [15:0] count_ff;
  // holding without a tick is what makes a frozen module resume where it stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= 16'h0000;
    end else if (tick_i) begin
      count_ff <= count_ff + 16'h0001;
    end
  end
  assign count_o = count_ff;
endmodule
`default_nettype wire

// ===== sim/test_clock_prescale_sleep_power_gating.sv
`timescale 1ns/10ps
`default_nettype none
module test_clock_prescale_sleep_power_gating;
  import clock_power_pkg::*;
  // ************************************************************
  // bench
  // ************************************************************
  logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, sleep_instr_i, ext_crystal_sel_i, timer2_async_i;
  logic external_interrupt_zero_level_mode_i, cpu_clk_en_o, flash_clk_en_o, io_clk_en_o, adc_clk_en_o, asy_clk_en_o;
  logic main_osc_en_o, timer_osc_en_o, timer2_sync_clk_en_o, sleeping_o;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o;
  logic [3:0] sel_i;
  logic [6:0] wake;
  logic [PRR_W-1:0] periph_clk_en_o, periph_access_en_o;
  logic [15:0] t1_count, t;
  int mismatches, checked;
  clock_power_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .sleep_instr_i(sleep_instr_i),
    .ext_crystal_sel_i(ext_crystal_sel_i), .timer2_async_i(timer2_async_i),
    .external_interrupt_zero_level_mode_i(external_interrupt_zero_level_mode_i), .external_interrupt_zero_i(wake[0]), .pin_change_i(wake[1]),
    .universal_serial_unit_start_i(wake[2]), .timer2_wake_i(wake[3]), .self_program_store_ready_i(wake[4]),
    .adc_done_i(wake[5]), .other_io_wake_i(wake[6]), .cpu_clk_en_o(cpu_clk_en_o),
    .flash_clk_en_o(flash_clk_en_o), .io_clk_en_o(io_clk_en_o), .adc_clk_en_o(adc_clk_en_o),
    .asy_clk_en_o(asy_clk_en_o), .main_osc_en_o(main_osc_en_o), .timer_osc_en_o(timer_osc_en_o),
    .timer2_sync_clk_en_o(timer2_sync_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .periph_access_en_o(periph_access_en_o), .sleeping_o(sleeping_o));
  gated_periph_model i_timer1 (.clk_i(clk_i), .rst_i(rst_i), .tick_i(periph_clk_en_o[3]), .count_o(t1_count));
  task automatic test_done();
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // outputs are read right at the edge, so the value is the one the edge samples
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    if (n >= 50) begin
      mismatches++;
      $display("[FAIL] %0t no bus answer", $time);
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic gaps(input int exp, input int mn);
    int last, n;
    int g[3];
    last = -1;
    n = 0;
    g = '{0, 0, 0};
    for (int i = 0; i < 80 && n < 3; i++) begin
      @(posedge clk_i);
      if (cpu_clk_en_o === 1'b1) begin
        if (last >= 0) begin
          g[n] = i - last;
          n++;
        end
        last = i;
      end
    end
    chk(32'(g[0] >= mn), 32'h1);
    chk(32'(g[1]), 32'(exp));
    chk(32'(g[2]), 32'(exp));
  endtask
  task automatic nap(input logic [2:0] kind, input logic [3:0] dom, input logic [6:0] bad,
                     input logic [6:0] good, input int lat);
    int n;
    wr(ADDR_SLEEP_CTRL, {28'h0, kind, 1'b1});
    sleep_instr_i <= 1'b1;
    @(posedge clk_i);
    sleep_instr_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({28'h0, io_clk_en_o, adc_clk_en_o, asy_clk_en_o, main_osc_en_o}, {28'h0, dom});
    // a reserved kind is ignored, so the core stays awake and keeps its clocks
    chk({30'h0, cpu_clk_en_o, flash_clk_en_o}, {30'h0, {2{kind == 3'h5}}});
    chk({31'h0, timer_osc_en_o}, {31'h0, kind == SLEEP_KIND_PSAVE || kind == 3'h5});
    wake <= bad;
    repeat (6) @(posedge clk_i);
    chk({31'h0, sleeping_o}, {31'h0, kind != 3'h5});
    wake <= good;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (sleeping_o !== 1'b0 && n < 300);
    wake <= 7'h00;
    if (kind != 3'h5) chk(32'(n), 32'(lat));
    @(posedge clk_i);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
  initial begin
    {rst_i, we_i, cyc_i, stb_i, sleep_instr_i, timer2_async_i, external_interrupt_zero_level_mode_i} = 7'h40;
    ext_crystal_sel_i = 1'b1;
    adr_i = 8'h00;
    dat_i = 32'h0;
    sel_i = 4'hF;
    wake = 7'h00;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADDR_PRESCALE, 32'h0);
    rd(ADDR_SLEEP_CTRL, 32'h0);
    rd(ADDR_POWER_RED, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    rd(8'h10, 32'h0);
    // the timer model holds nothing shared, so it needs no disabling before its clock stops
    wr(ADDR_POWER_RED, 32'h000000FF);
    rd(ADDR_POWER_RED, 32'h0000000F);
    chk({28'h0, periph_access_en_o}, 32'h0);
    t = t1_count;
    repeat (20) @(posedge clk_i);
    chk({16'h0, t1_count}, {16'h0, t});
    wr(ADDR_POWER_RED, 32'h0);
    repeat (4) @(posedge clk_i);
    chk(32'(t1_count > t && t1_count <= t + 16'h000C), 32'h1);
    wr(ADDR_PRESCALE, 32'h2);
    gaps(4, 4);
    wr(ADDR_PRESCALE, 32'h3);
    gaps(8, 8);
    wr(ADDR_PRESCALE, 32'hD);
    rd(ADDR_PRESCALE, 32'h3);
    wr(ADDR_PRESCALE, 32'h0);
    repeat (20) @(posedge clk_i);
    rd(ADDR_PRESCALE, 32'h0);
    timer2_async_i <= 1'b1;
    nap(SLEEP_KIND_IDLE, 4'hF, 7'h08, 7'h40, 4);
    nap(SLEEP_KIND_ADC, 4'h7, 7'h41, 7'h20, 4);
    nap(SLEEP_KIND_PDOWN, 4'h0, 7'h79, 7'h04, int'(OSC_START_CYCLES) + 3);
    nap(SLEEP_KIND_PSAVE, 4'h2, 7'h71, 7'h08, int'(OSC_START_CYCLES) + 3);
    nap(SLEEP_KIND_STANDBY, 4'h1, 7'h79, 7'h02, int'(STANDBY_WAKE_CYCLES) + 3);
    nap(3'h5, 4'hF, 7'h00, 7'h00, 0);
    external_interrupt_zero_level_mode_i <= 1'b1;
    nap(SLEEP_KIND_PDOWN, 4'h0, 7'h00, 7'h01, int'(OSC_START_CYCLES) + 3);
    ext_crystal_sel_i <= 1'b0;
    nap(SLEEP_KIND_STANDBY, 4'h0, 7'h00, 7'h02, int'(OSC_START_CYCLES) + 3);
    test_done();
  end
endmodule
`default_nettype wire
